// ===== rtl/temperature_alarm_register_map.sv
// register bank, alarms and output control of a temperature input module
// Function
// [RQ1] Set high alarm flag when temperature exceeds the high threshold.
// [RQ2] Set low alarm flag when temperature drops below the low threshold.
// [RQ3] Latch mode zero: flags follow the present temperature only.
// [RQ4] Latch mode one: flags stay set until the master clears them.
// [RQ5] Output mode zero: output follows the master's written state.
// [RQ6] Cooling mode: output on while value is above the setpoint.
// [RQ7] Heating mode: output on while value is below the setpoint.
// [RQ8] Writable hysteresis applies to automatic output switching.
// [RQ9] Input type register selects measurement; zero disables, up to 18.
// [RQ10] Read-only bit shows sensor connected.
// [RQ11] Read-write bit shows output; master write changes it.
// [RQ12] Read-only register reports junction temperature.
// [RQ13] Writable constant junction temperature for cold-junction handling.
// [RQ14] Writable offset added to the junction temperature.
// [RQ15] Writable lead wire resistance for resistive measurements.
// [RQ16] Read-only register reports the sensor measurement current.
// [RQ17] Compared temperature is in tenths of a degree Celsius.
// [RQ18] Automatic output releases only after returning past the hysteresis band.
module temperature_alarm_register_map (
   input  wire logic        clk,              // 10 MHz clock
   input  wire logic        reset,            // synchronous, active high
   input  wire logic        req,              // access request strobe
   input  wire logic        we,               // 1 write, 0 read
   input  wire logic        bit_space,        // 1 bit space, 0 word space
   input  wire logic [15:0] addr,             // register or bit offset
   input  wire logic [15:0] wdata,            // write data, bit in [0]
   output logic      [15:0] rdata,            // read data
   output logic             ack,              // answer pulse
   output logic             err,              // refused access, with ack
   input  wire logic [15:0] temp_value,       // measured value, tenths of degree
   input  wire logic        temp_valid,       // new measured value
   input  wire logic [15:0] junction_raw,     // raw junction temperature
   input  wire logic [15:0] sense_current_in, // present measurement current
   input  wire logic        sensor_pin,       // sensor detect, asynchronous
   output logic      [15:0] input_type,       // selected measurement type
   output logic      [15:0] fixed_junction,   // constant junction temperature
   output logic      [15:0] junction_temp,    // corrected junction temperature
   output logic      [15:0] lead_resistance,  // lead wire resistance
   output logic             digital_out,      // digital output state
   output logic             alarm_high,       // over-temperature flag
   output logic             alarm_low         // under-temperature flag
);

   // ---------------------------------------------------------------
   // sensor detect synchroniser
   // ---------------------------------------------------------------
   logic sense_meta_ff;
   logic sense_sync_ff;

   // two stages; only the second stage is read by logic
   always_ff @(posedge clk) begin
      if (reset) begin
         sense_meta_ff <= 1'b0;
         sense_sync_ff <= 1'b0;
      end else begin
         sense_meta_ff <= sensor_pin;
         sense_sync_ff <= sense_meta_ff;
      end
   end

   // ---------------------------------------------------------------
   // access decode
   // ---------------------------------------------------------------
   logic wr_word;
   logic wr_bit;
   logic word_rw;
   logic word_ro;
   logic bad_type;

   // classify the request; bad input codes are refused outright
   always_comb begin
      wr_word  = req && we && !bit_space;
      wr_bit   = req && we && bit_space;
      word_ro  = (addr == temp_alarm_pkg::ADDR_JUNCTION_TEMP) ||
                 (addr == temp_alarm_pkg::ADDR_SENSE_CURRENT);
      word_rw  = (addr >= temp_alarm_pkg::ADDR_HIGH_THRESHOLD) &&
                 (addr <= temp_alarm_pkg::ADDR_LEAD_WIRE);
      bad_type = (addr == temp_alarm_pkg::ADDR_INPUT_TYPE) &&
                 (wdata > temp_alarm_pkg::INPUT_TYPE_MAX);
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   logic [15:0] high_th_ff, nxt_high_th;
   logic [15:0] low_th_ff, nxt_low_th;
   logic [15:0] latch_ff, nxt_latch;
   logic [15:0] fixed_jt_ff, nxt_fixed_jt;
   logic [15:0] jt_off_ff, nxt_jt_off;
   logic [15:0] type_ff, nxt_type;
   logic [15:0] omode_ff, nxt_omode;
   logic [15:0] setp_ff, nxt_setp;
   logic [15:0] hyst_ff, nxt_hyst;
   logic [15:0] lead_ff, nxt_lead;
   logic        cfg_we;

   // a word write lands only on a mapped read-write offset
   always_comb begin
      cfg_we       = wr_word && word_rw && !bad_type;
      nxt_high_th  = high_th_ff;
      nxt_low_th   = low_th_ff;
      nxt_latch    = latch_ff;
      nxt_fixed_jt = fixed_jt_ff;
      nxt_jt_off   = jt_off_ff;
      nxt_type     = type_ff;
      nxt_omode    = omode_ff;
      nxt_setp     = setp_ff;
      nxt_hyst     = hyst_ff;
      nxt_lead     = lead_ff;
      if (cfg_we) begin
         case (addr)
            temp_alarm_pkg::ADDR_HIGH_THRESHOLD:  nxt_high_th  = wdata;
            temp_alarm_pkg::ADDR_LOW_THRESHOLD:   nxt_low_th   = wdata;
            temp_alarm_pkg::ADDR_ALARM_LATCH:     nxt_latch    = wdata;
            // [RQ13] constant junction value
            temp_alarm_pkg::ADDR_FIXED_JUNCTION:  nxt_fixed_jt = wdata;
            temp_alarm_pkg::ADDR_JUNCTION_OFFSET: nxt_jt_off   = wdata;
            // [RQ9] input type select
            temp_alarm_pkg::ADDR_INPUT_TYPE:      nxt_type     = wdata;
            temp_alarm_pkg::ADDR_OUTPUT_MODE:     nxt_omode    = wdata;
            temp_alarm_pkg::ADDR_SETPOINT:        nxt_setp     = wdata;
            // [RQ8] hysteresis band
            temp_alarm_pkg::ADDR_HYSTERESIS:      nxt_hyst     = wdata;
            // [RQ15] lead wire resistance
            temp_alarm_pkg::ADDR_LEAD_WIRE:       nxt_lead     = wdata;
            default: ;
         endcase
      end
   end

   // register the configuration
   always_ff @(posedge clk) begin
      if (reset) begin
         high_th_ff  <= temp_alarm_pkg::RST_HIGH_THRESHOLD;
         low_th_ff   <= temp_alarm_pkg::RST_LOW_THRESHOLD;
         latch_ff    <= temp_alarm_pkg::RST_ALARM_LATCH;
         fixed_jt_ff <= temp_alarm_pkg::RST_FIXED_JUNCTION;
         jt_off_ff   <= temp_alarm_pkg::RST_JUNCTION_OFFSET;
         type_ff     <= temp_alarm_pkg::RST_INPUT_TYPE;
         omode_ff    <= temp_alarm_pkg::RST_OUTPUT_MODE;
         setp_ff     <= temp_alarm_pkg::RST_SETPOINT;
         hyst_ff     <= temp_alarm_pkg::RST_HYSTERESIS;
         lead_ff     <= temp_alarm_pkg::RST_LEAD_WIRE;
      end else begin
         high_th_ff  <= nxt_high_th;
         low_th_ff   <= nxt_low_th;
         latch_ff    <= nxt_latch;
         fixed_jt_ff <= nxt_fixed_jt;
         jt_off_ff   <= nxt_jt_off;
         type_ff     <= nxt_type;
         omode_ff    <= nxt_omode;
         setp_ff     <= nxt_setp;
         hyst_ff     <= nxt_hyst;
         lead_ff     <= nxt_lead;
      end
   end

   // ---------------------------------------------------------------
   // measurement capture
   // ---------------------------------------------------------------
   logic [15:0] temp_ff, nxt_temp;
   logic        seen_ff, nxt_seen;
   logic [15:0] jt_ff, nxt_jt;
   logic [15:0] cur_ff, nxt_cur;

   // hold last sample; nothing is compared before the first one
   always_comb begin
      // [RQ17] value kept in tenths
      nxt_temp = temp_valid ? temp_value : temp_ff;
      nxt_seen = seen_ff || temp_valid;
      // [RQ14] offset on junction
      nxt_jt   = junction_raw + jt_off_ff;
      // [RQ16] current sampled
      nxt_cur  = sense_current_in;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         temp_ff <= 16'h0000;
         seen_ff <= 1'b0;
         jt_ff   <= 16'h0000;
         cur_ff  <= 16'h0000;
      end else begin
         temp_ff <= nxt_temp;
         seen_ff <= nxt_seen;
         jt_ff   <= nxt_jt;
         cur_ff  <= nxt_cur;
      end
   end

   // ---------------------------------------------------------------
   // alarm flags
   // ---------------------------------------------------------------
   logic hi_ff, nxt_hi;
   logic lo_ff, nxt_lo;
   logic cond_hi;
   logic cond_lo;
   logic alarm_clr;
   logic latched;

   // a disabled input never raises an alarm
   always_comb begin
      latched   = latch_ff[temp_alarm_pkg::LATCH_MODE_POS];
      alarm_clr = wr_bit && (addr == temp_alarm_pkg::BIT_ALARM_STATE) && !wdata[0];
      // [RQ1] above high threshold
      cond_hi   = seen_ff && (type_ff != temp_alarm_pkg::INPUT_DISABLED) &&
                  temp_alarm_pkg::signed_gt(temp_ff, high_th_ff);
      // [RQ2] below low threshold
      cond_lo   = seen_ff && (type_ff != temp_alarm_pkg::INPUT_DISABLED) &&
                  temp_alarm_pkg::signed_gt(low_th_ff, temp_ff);
      if (latched) begin
         // [RQ4] sticky, set beats clear
         nxt_hi = cond_hi || (hi_ff && !alarm_clr);
         nxt_lo = cond_lo || (lo_ff && !alarm_clr);
      end else begin
         // [RQ3] live flags
         nxt_hi = cond_hi;
         nxt_lo = cond_lo;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         hi_ff <= 1'b0;
         lo_ff <= 1'b0;
      end else begin
         hi_ff <= nxt_hi;
         lo_ff <= nxt_lo;
      end
   end

   // ---------------------------------------------------------------
   // digital output
   // ---------------------------------------------------------------
   logic out_ff, nxt_out;
   logic auto_on;
   logic auto_mode;

   thermo_switch u_switch (
      .value      (temp_ff),
      .setpoint   (setp_ff),
      .hysteresis (hyst_ff),
      .cool       (omode_ff[temp_alarm_pkg::MODE_COOL_POS]),
      .heat       (omode_ff[temp_alarm_pkg::MODE_HEAT_POS]),
      .cur_on     (out_ff),
      .nxt_on     (auto_on)
   );

   // automatic modes override the master; no sample means no switching
   always_comb begin
      auto_mode = omode_ff[temp_alarm_pkg::MODE_COOL_POS] ||
                  omode_ff[temp_alarm_pkg::MODE_HEAT_POS];
      nxt_out   = out_ff;
      if (auto_mode) begin
         if (seen_ff)
            nxt_out = auto_on;
      // [RQ5] [RQ11] master drives output
      end else if (wr_bit && (addr == temp_alarm_pkg::BIT_OUTPUT_STATE)) begin
         nxt_out = wdata[0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset)
         out_ff <= 1'b0;
      else
         out_ff <= nxt_out;
   end

   // ---------------------------------------------------------------
   // answer path
   // ---------------------------------------------------------------
   logic [15:0] rdata_ff, nxt_rdata;
   logic        ack_ff, nxt_ack;
   logic        err_ff, nxt_err;

   // read mux; unmapped or read-only writes answer with err
   always_comb begin
      nxt_ack   = req;
      nxt_err   = 1'b0;
      nxt_rdata = 16'h0000;
      if (req && !bit_space) begin
         case (addr)
            // [RQ12] junction readback
            temp_alarm_pkg::ADDR_JUNCTION_TEMP:   nxt_rdata = jt_ff;
            temp_alarm_pkg::ADDR_SENSE_CURRENT:   nxt_rdata = cur_ff;
            temp_alarm_pkg::ADDR_HIGH_THRESHOLD:  nxt_rdata = high_th_ff;
            temp_alarm_pkg::ADDR_LOW_THRESHOLD:   nxt_rdata = low_th_ff;
            temp_alarm_pkg::ADDR_ALARM_LATCH:     nxt_rdata = latch_ff;
            temp_alarm_pkg::ADDR_FIXED_JUNCTION:  nxt_rdata = fixed_jt_ff;
            temp_alarm_pkg::ADDR_JUNCTION_OFFSET: nxt_rdata = jt_off_ff;
            temp_alarm_pkg::ADDR_INPUT_TYPE:      nxt_rdata = type_ff;
            temp_alarm_pkg::ADDR_OUTPUT_MODE:     nxt_rdata = omode_ff;
            temp_alarm_pkg::ADDR_SETPOINT:        nxt_rdata = setp_ff;
            temp_alarm_pkg::ADDR_HYSTERESIS:      nxt_rdata = hyst_ff;
            temp_alarm_pkg::ADDR_LEAD_WIRE:       nxt_rdata = lead_ff;
            default:                              nxt_err   = 1'b1;
         endcase
         if (we && (word_ro || bad_type))
            nxt_err = 1'b1;
         if (we)
            nxt_rdata = 16'h0000;
      end else if (req) begin
         case (addr)
            // [RQ10] sensor present bit
            temp_alarm_pkg::BIT_SENSOR_PRESENT: begin
               nxt_rdata = {15'h0000, sense_sync_ff};
               nxt_err   = we;
            end
            temp_alarm_pkg::BIT_ALARM_STATE:  nxt_rdata = {15'h0000, hi_ff || lo_ff};
            temp_alarm_pkg::BIT_OUTPUT_STATE: nxt_rdata = {15'h0000, out_ff};
            default:                          nxt_err   = 1'b1;
         endcase
         if (we)
            nxt_rdata = 16'h0000;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_ff <= 16'h0000;
         ack_ff   <= 1'b0;
         err_ff   <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         ack_ff   <= nxt_ack;
         err_ff   <= nxt_err;
      end
   end

   // outputs straight from flip-flops
   assign rdata           = rdata_ff;
   assign ack             = ack_ff;
   assign err             = err_ff;
   assign input_type      = type_ff;
   assign fixed_junction  = fixed_jt_ff;
   assign junction_temp   = jt_ff;
   assign lead_resistance = lead_ff;
   assign digital_out     = out_ff;
   assign alarm_high      = hi_ff;
   assign alarm_low       = lo_ff;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence hot_sample;
      temp_valid && (type_ff != 16'h0000) &&
      temp_alarm_pkg::signed_gt(temp_value, high_th_ff) && !cfg_we;
   endsequence

   chk_high_sets: assert property (hot_sample |-> ##2 alarm_high) // [RQ1]
      else $error("high alarm not raised two cycles after hot sample");
   chk_low_sets: assert property ( // [RQ2]
      temp_valid && (type_ff != 16'h0000) && !cfg_we &&
      temp_alarm_pkg::signed_gt(low_th_ff, temp_value) |-> ##2 alarm_low)
      else $error("low alarm not raised two cycles after cold sample");
   chk_live_drops: assert property ( // [RQ3]
      !latched && !cond_hi |=> !alarm_high)
      else $error("live high alarm stayed set without cause");
   chk_latch_holds: assert property ( // [RQ4]
      latched && alarm_high && !alarm_clr && !cfg_we |=> alarm_high)
      else $error("latched alarm dropped without master clear");
   chk_master_out: assert property ( // [RQ11]
      !auto_mode && wr_bit && addr == temp_alarm_pkg::BIT_OUTPUT_STATE
      |=> digital_out == $past(wdata[0]))
      else $error("master write did not reach digital output");
   chk_master_hold: assert property ( // [RQ5]
      !auto_mode && !wr_bit && !cfg_we |=> $stable(digital_out))
      else $error("output changed by itself in master mode");
   chk_cool_on: assert property ( // [RQ6]
      omode_ff[8] && seen_ff && temp_alarm_pkg::signed_gt(temp_ff, setp_ff) |=> digital_out)
      else $error("cooling output not on above setpoint");
   chk_heat_on: assert property ( // [RQ7]
      !omode_ff[8] && omode_ff[9] && seen_ff &&
      temp_alarm_pkg::signed_gt(setp_ff, temp_ff) |=> digital_out)
      else $error("heating output not on below setpoint");
   chk_band_hold: assert property ( // [RQ18]
      omode_ff[8] && digital_out && !cfg_we &&
      $signed({{2{temp_ff[15]}}, temp_ff}) >
      $signed({{2{setp_ff[15]}}, setp_ff} - {2'b00, hyst_ff})
      |=> digital_out)
      else $error("cooling output released inside hysteresis band");
   chk_type_refused: assert property ( // [RQ9]
      wr_word && bad_type |=> ack && err && $stable(type_ff))
      else $error("out-of-range input type was accepted");

endmodule // temperature_alarm_register_map

// ===== rtl/temp_alarm_pkg.sv
// constants shared by the temperature alarm register bank
package temp_alarm_pkg;

   // ---------------------------------------------------------------
   // word register offsets
   // ---------------------------------------------------------------
   localparam logic [15:0] ADDR_JUNCTION_TEMP   = 16'h0035;
   localparam logic [15:0] ADDR_SENSE_CURRENT   = 16'h0036;
   localparam logic [15:0] ADDR_HIGH_THRESHOLD  = 16'h0037;
   localparam logic [15:0] ADDR_LOW_THRESHOLD   = 16'h0038;
   localparam logic [15:0] ADDR_ALARM_LATCH     = 16'h0039;
   localparam logic [15:0] ADDR_FIXED_JUNCTION  = 16'h003a;
   localparam logic [15:0] ADDR_JUNCTION_OFFSET = 16'h003b;
   localparam logic [15:0] ADDR_INPUT_TYPE      = 16'h003c;
   localparam logic [15:0] ADDR_OUTPUT_MODE     = 16'h003d;
   localparam logic [15:0] ADDR_SETPOINT        = 16'h003e;
   localparam logic [15:0] ADDR_HYSTERESIS      = 16'h003f;
   localparam logic [15:0] ADDR_LEAD_WIRE       = 16'h0040;

   // ---------------------------------------------------------------
   // single-bit offsets
   // ---------------------------------------------------------------
   localparam logic [15:0] BIT_SENSOR_PRESENT   = 16'h0320;
   localparam logic [15:0] BIT_ALARM_STATE      = 16'h0330;
   localparam logic [15:0] BIT_OUTPUT_STATE     = 16'h0331;

   // ---------------------------------------------------------------
   // field positions and codes
   // ---------------------------------------------------------------
   localparam int          LATCH_MODE_POS       = 0;
   localparam int          MODE_COOL_POS        = 8;
   localparam int          MODE_HEAT_POS        = 9;
   localparam logic [15:0] INPUT_DISABLED       = 16'h0000;
   localparam logic [15:0] INPUT_TYPE_MAX       = 16'h0012;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_HIGH_THRESHOLD   = 16'h03e8;
   localparam logic [15:0] RST_LOW_THRESHOLD    = 16'h0000;
   localparam logic [15:0] RST_ALARM_LATCH      = 16'h0000;
   localparam logic [15:0] RST_FIXED_JUNCTION   = 16'h00fa;
   localparam logic [15:0] RST_JUNCTION_OFFSET  = 16'h0000;
   localparam logic [15:0] RST_INPUT_TYPE       = 16'h0000;
   localparam logic [15:0] RST_OUTPUT_MODE      = 16'h0000;
   localparam logic [15:0] RST_SETPOINT         = 16'h0000;
   localparam logic [15:0] RST_HYSTERESIS       = 16'h0000;
   localparam logic [15:0] RST_LEAD_WIRE        = 16'h0000;

   // signed greater-than on tenths of a degree
   function automatic logic signed_gt(input logic [15:0] a, input logic [15:0] b);
      signed_gt = $signed(a) > $signed(b);
   endfunction

endpackage

// ===== rtl/thermo_switch.sv
// two-point switch with hysteresis for the digital output
module thermo_switch (
   input  wire logic [15:0] value,      // measured value, signed
   input  wire logic [15:0] setpoint,   // switching point, signed
   input  wire logic [15:0] hysteresis, // release band, unsigned
   input  wire logic        cool,       // on above setpoint
   input  wire logic        heat,       // on below setpoint
   input  wire logic        cur_on,     // present output state
   output logic             nxt_on      // next output state
);

   // ---------------------------------------------------------------
   // widened arithmetic
   // ---------------------------------------------------------------
   // eighteen bits so setpoint plus or minus a full band never wraps
   logic signed [17:0] val_w;
   logic signed [17:0] set_w;
   logic signed [17:0] band_w;
   logic signed [17:0] release_lo;
   logic signed [17:0] release_hi;

   // sign-extend value and setpoint, zero-extend the band, and form the two release points
   always_comb begin
      val_w      = {{2{value[15]}}, value};
      set_w      = {{2{setpoint[15]}}, setpoint};
      band_w     = {2'b00, hysteresis};
      release_lo = set_w - band_w;
      release_hi = set_w + band_w;
   end

   // ---------------------------------------------------------------
   // decision
   // ---------------------------------------------------------------
   // cooling has priority when both modes are requested
   always_comb begin
      nxt_on = cur_on;
      if (cool) begin
         // [RQ6] cooling turn on
         if (val_w > set_w)
            nxt_on = 1'b1;
         // [RQ18] release past band
         else if (val_w <= release_lo)
            nxt_on = 1'b0;
      end else if (heat) begin
         // [RQ7] heating turn on
         if (val_w < set_w)
            nxt_on = 1'b1;
         // [RQ18] release past band
         else if (val_w >= release_hi)
            nxt_on = 1'b0;
      end
   end

endmodule // thermo_switch

// ===== testbench/reg_master.sv
// register bus master model issuing one access at a time
module reg_master (
   input  wire logic        clk,       // bench clock
   input  wire logic        ack,       // answer pulse
   input  wire logic        err,       // refusal flag
   input  wire logic [15:0] rdata,     // read data
   output logic             req,       // request strobe
   output logic             we,        // write select
   output logic             bit_space, // bit space select
   output logic      [15:0] addr,      // offset
   output logic      [15:0] wdata      // write data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      req = 1'b0;
   end
   // ---------------------------------------------------------------
   // single access
   // ---------------------------------------------------------------
   // clears and output writes come through here
   // strobe is one cycle; answer is sampled settled, just after edges
   task automatic access(input logic w, b, input logic [15:0] a, d,
                         output logic [15:0] q, output logic e, ok);
      ok = 1'b0;
      @(posedge clk);
      req <= 1'b1;
      we <= w;
      bit_space <= b;
      addr <= a;
      wdata <= d;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge clk);
         req <= 1'b0;
         #1;
         if (ack === 1'b1) begin
            q = rdata;
            e = err;
            ok = 1'b1;
         end
      end
   endtask
endmodule // reg_master

// ===== testbench/temperature_alarm_register_map_tb.sv
// self-checking bench of the temperature alarm register bank
module temperature_alarm_register_map_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, reset, req, we, bit_space, ack, err, temp_valid, sensor_pin;
   logic        digital_out, alarm_high, alarm_low;
   logic [15:0] addr, wdata, rdata, temp_value, junction_raw, sense_current_in;
   logic [15:0] input_type, fixed_junction, junction_temp, lead_resistance;
   int          bad_count = 0;
   int          n_tests = 0;
   temperature_alarm_register_map temperature_alarm_register_map_inst (
      .clk(clk), .reset(reset), .req(req), .we(we), .bit_space(bit_space),
      .addr(addr), .wdata(wdata), .rdata(rdata), .ack(ack), .err(err),
      .temp_value(temp_value), .temp_valid(temp_valid), .junction_raw(junction_raw),
      .sense_current_in(sense_current_in), .sensor_pin(sensor_pin),
      .input_type(input_type), .fixed_junction(fixed_junction),
      .junction_temp(junction_temp), .lead_resistance(lead_resistance),
      .digital_out(digital_out), .alarm_high(alarm_high), .alarm_low(alarm_low));
   reg_master reg_master_inst (.clk(clk), .ack(ack), .err(err), .rdata(rdata), .req(req),
      .we(we), .bit_space(bit_space), .addr(addr), .wdata(wdata));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one access, judged on read data and refusal; a lost answer ends the run
   task automatic acc(input logic w, b, input logic [15:0] a, d, q_exp, input logic e_exp);
      logic [15:0] q;
      logic        e, ok;
      reg_master_inst.access(w, b, a, d, q, e, ok);
      if (ok !== 1'b1) begin
         bad_count++;
         finish_test();
      end else begin
         check(q, q_exp);
         check({15'h0000, e}, {15'h0000, e_exp});
      end
   endtask
   // one sample, then time for the two-cycle flag latency to pass
   task automatic meas(input logic [15:0] v);
      @(posedge clk);
      temp_value <= v;
      temp_valid <= 1'b1;
      @(posedge clk);
      temp_valid <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      acc(0, 0, 16'h37, 16'h0, 16'h3e8, 0);
      acc(0, 0, 16'h41, 16'h0, 16'h0, 1);
      acc(1, 0, 16'h35, 16'h7, 16'h0, 1);
      acc(1, 0, 16'h3b, 16'h2, 16'h0, 0);
      acc(0, 0, 16'h35, 16'h0, 16'h102, 0);
      check(junction_temp, 16'h102);
      acc(0, 0, 16'h36, 16'h0, 16'h33, 0);
      acc(1, 0, 16'h40, 16'h9, 16'h0, 0);
      check(lead_resistance, 16'h9);
      acc(1, 0, 16'h3a, 16'h123, 16'h0, 0);
      check(fixed_junction, 16'h123);
      acc(1, 0, 16'h3c, 16'h13, 16'h0, 1);
      acc(1, 0, 16'h3c, 16'h3, 16'h0, 0);
      check(input_type, 16'h3);
      acc(1, 1, 16'h320, 16'h1, 16'h0, 1);
   endtask
   // live flags, boundary and negative values, disabled input
   task automatic t_live();
      meas(16'h3e8);
      check({15'h0, alarm_high}, 16'h0);
      meas(16'h3e9);
      check({15'h0, alarm_high}, 16'h1);
      acc(0, 1, 16'h330, 16'h0, 16'h1, 0);
      meas(16'h100);
      check({15'h0, alarm_high}, 16'h0);
      acc(1, 0, 16'h38, 16'h50, 16'h0, 0);
      meas(16'hfff0);
      check({15'h0, alarm_low}, 16'h1);
      meas(16'h100);
      check({15'h0, alarm_low}, 16'h0);
      acc(1, 0, 16'h3c, 16'h0, 16'h0, 0);
      meas(16'h3e9);
      check({15'h0, alarm_high}, 16'h0);
      acc(1, 0, 16'h3c, 16'h3, 16'h0, 0);
   endtask
   task automatic t_latch();
      acc(1, 0, 16'h39, 16'h1, 16'h0, 0);
      meas(16'h3e9);
      meas(16'h100);
      check({15'h0, alarm_high}, 16'h1);
      acc(1, 1, 16'h330, 16'h0, 16'h0, 0);
      check({15'h0, alarm_high}, 16'h0);
      acc(1, 0, 16'h39, 16'h0, 16'h0, 0);
   endtask
   task automatic t_output();
      acc(1, 1, 16'h331, 16'h1, 16'h0, 0);
      check({15'h0, digital_out}, 16'h1);
      acc(0, 1, 16'h331, 16'h0, 16'h1, 0);
      acc(1, 0, 16'h3e, 16'h200, 16'h0, 0);
      acc(1, 0, 16'h3f, 16'h10, 16'h0, 0);
      acc(1, 0, 16'h3d, 16'h100, 16'h0, 0);
      meas(16'h201);
      check({15'h0, digital_out}, 16'h1);
      meas(16'h1f1);
      check({15'h0, digital_out}, 16'h1);
      meas(16'h1f0);
      check({15'h0, digital_out}, 16'h0);
      acc(1, 1, 16'h331, 16'h1, 16'h0, 0);
      check({15'h0, digital_out}, 16'h0);
      acc(1, 0, 16'h3d, 16'h200, 16'h0, 0);
      meas(16'h1ff);
      check({15'h0, digital_out}, 16'h1);
      meas(16'h20f);
      check({15'h0, digital_out}, 16'h1);
      meas(16'h210);
      check({15'h0, digital_out}, 16'h0);
      // both modes requested: cooling takes priority above the setpoint
      acc(1, 0, 16'h3d, 16'h300, 16'h0, 0);
      meas(16'h210);
      check({15'h0, digital_out}, 16'h1);
   endtask
   task automatic t_sensor();
      acc(0, 1, 16'h320, 16'h0, 16'h0, 0);
      @(posedge clk);
      sensor_pin <= 1'b1;
      repeat (3) @(posedge clk);
      acc(0, 1, 16'h320, 16'h0, 16'h1, 0);
   endtask
   // ---------------------------------------------------------------
   // clock, reset and main sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      reset = 1'b1;
      temp_valid = 1'b0;
      temp_value = 16'h0000;
      sensor_pin = 1'b0;
      junction_raw = 16'h0100;
      sense_current_in = 16'h0033;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_live();
      t_latch();
      t_output();
      t_sensor();
      finish_test();
   end
endmodule // temperature_alarm_register_map_tb
